// file: inc/ccc_pkg.sv
package ccc_pkg;

    // ****************************************************
    // register map
    // ****************************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h1;
    localparam logic [3:0] ADDR_VALUE = 4'h2;
    localparam logic [3:0] ADDR_BUFFER = 4'h3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CTRL_WMASK = 16'hFF7F;
    localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
    localparam logic [15:0] IRQ_EN_WMASK = 16'h3FFF;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // ****************************************************
    // field codes
    // ****************************************************
    localparam logic [2:0] LOAD_IMMEDIATE = 3'h0;
    localparam logic [2:0] LOAD_END = 3'h1;
    localparam logic [2:0] LOAD_MATCH = 3'h2;
    localparam logic [2:0] LOAD_WRAP = 3'h3;
    localparam logic [2:0] LOAD_MATCH_RESET = 3'h4;
    localparam logic [1:0] SRC_PIN = 2'h0;
    localparam logic [1:0] SRC_SW_LOW = 2'h2;
    localparam logic [1:0] SRC_SW_HIGH = 2'h3;
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [2:0] WAVE_SOFTWARE = 3'h0;

    typedef enum logic [1:0] {
        DIR_DOWN = 2'b00,
        DIR_UP = 2'b01,
        DIR_UPDOWN = 2'b10
    } count_dir_t;

    typedef struct packed {
        logic capture_sync_select;
        logic [2:0] buffer_load_mode;
        logic [1:0] capture_source;
        logic [1:0] capture_edge;
        logic reserved;
        logic paired_match_select;
        logic software_output_level;
        logic [2:0] output_waveform_mode;
        logic output_invert;
        logic comparator_or_capture_select;
    } ctrl_t;

    typedef struct packed {
        logic [15:0] count;
        logic at_max;
        logic at_zero;
        logic wrap;
        count_dir_t dir;
    } counter_view_t;

endpackage : ccc_pkg

// file: rtl/timer_compare_capture_control.sv
module timer_compare_capture_control
    import ccc_pkg::*;
#(
    parameter logic [5:0] CIRCUIT_PRESENT = 6'h3F
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire counter_view_t counter_in,
    input wire logic capture_input_pin,
    input wire logic own_match,
    input wire logic partner_match,
    input wire logic [13:0] irq_sources,
    output logic [13:0] irq_requests,
    output logic [15:0] compare_buffer,
    output logic counter_reset,
    output logic [15:0] reset_value,
    output logic capture_event,
    output logic timer_output,
    output logic use_paired_match,
    output logic match_for_wave,
    output logic max_for_wave,
    output logic zero_for_wave
);

    // ****************************************************
    // registers
    // ****************************************************
    ctrl_t ctrl_reg;
    logic [15:0] irq_en_reg;
    logic [15:0] value_reg;
    logic value_written_reg;
    logic [1:0] prev_source_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic pin_prev_reg;
    logic pin_async_prev_reg;

    // ****************************************************
    // decode
    // ****************************************************
    function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                      input logic fall);
        edge_hit = (sel[0] & rise) | (sel[1] & fall);
    endfunction : edge_hit

    wire logic [15:0] irq_en_mask;
    wire logic is_capture;
    wire logic wr_ctrl;
    wire logic wr_irq_en;
    wire logic wr_value;
    wire logic prev_match;
    logic load_due;
    wire logic load_now;
    wire logic [1:0] src_next;
    wire logic sw_rise;
    wire logic sw_fall;
    wire logic pin_rise;
    wire logic pin_fall;
    wire logic pin_level;
    wire logic pin_prev;
    logic trig_hit;
    wire logic [15:0] ctrl_bits;
    wire logic [15:0] rdata_next;
    ctrl_t ctrl_next;

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_mask
            assign irq_en_mask[2 * gi + 3 -: 2] =
                {2{CIRCUIT_PRESENT[gi]}};
        end
    endgenerate
    assign irq_en_mask[1:0] = 2'h3;
    assign irq_en_mask[15:14] = 2'h0;

    assign is_capture = ctrl_reg.comparator_or_capture_select;
    assign wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    assign wr_irq_en = reg_wr && (reg_addr == ADDR_IRQ_EN);
    assign wr_value = reg_wr && (reg_addr == ADDR_VALUE) && !is_capture;
    assign ctrl_bits = ctrl_reg;
    assign ctrl_next = (reg_wdata & CTRL_WMASK);
    assign src_next = wr_ctrl ? ctrl_next.capture_source
                              : ctrl_reg.capture_source;

    // previous-value match against the active buffer
    assign prev_match = (counter_in.count == compare_buffer);

    always_comb begin
        unique case (ctrl_reg.buffer_load_mode)
            LOAD_IMMEDIATE: load_due = value_written_reg;
            LOAD_END: begin
                unique case (counter_in.dir)
                    DIR_UP: load_due = counter_in.at_max;
                    DIR_DOWN: load_due = counter_in.at_zero;
                    default: load_due = counter_in.at_max
                        | counter_in.at_zero;
                endcase
            end
            LOAD_MATCH: load_due = prev_match;
            LOAD_WRAP: begin
                if (counter_in.dir == DIR_UPDOWN) begin
                    load_due = prev_match
                        | (counter_in.wrap & counter_in.at_zero);
                end else begin
                    load_due = counter_in.wrap;
                end
            end
            LOAD_MATCH_RESET: load_due = prev_match;
            default: load_due = 1'b0;
        endcase
    end
    assign load_now = load_due && !is_capture;

    // software trigger from source field transitions
    assign sw_rise = wr_ctrl && (ctrl_reg.capture_source == SRC_SW_LOW)
        && (ctrl_next.capture_source == SRC_SW_HIGH);
    assign sw_fall = wr_ctrl && (ctrl_reg.capture_source == SRC_SW_HIGH)
        && (ctrl_next.capture_source == SRC_SW_LOW);

    // sync path adds a clock; async path reads the synchroniser output
    assign pin_level = ctrl_reg.capture_sync_select
        ? pin_async_prev_reg : pin_sync_reg;
    assign pin_prev = pin_prev_reg;
    assign pin_rise = pin_level & ~pin_prev;
    assign pin_fall = ~pin_level & pin_prev;

    always_comb begin
        unique case (ctrl_reg.capture_source)
            SRC_PIN: trig_hit =
                edge_hit(ctrl_reg.capture_edge, pin_rise, pin_fall);
            SRC_SW_LOW,
            SRC_SW_HIGH: trig_hit =
                edge_hit(ctrl_reg.capture_edge, sw_rise, sw_fall);
            default: trig_hit = 1'b0;
        endcase
    end

    assign rdata_next =
        (reg_addr == ADDR_CTRL) ? ctrl_bits :
        (reg_addr == ADDR_IRQ_EN) ? irq_en_reg :
        (reg_addr == ADDR_VALUE) ? value_reg :
        (reg_addr == ADDR_BUFFER) ? compare_buffer : 16'h0000;

    // ****************************************************
    // pin synchroniser
    // ****************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_async_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= capture_input_pin;
            pin_sync_reg <= pin_meta_reg;
            pin_async_prev_reg <= pin_sync_reg;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_prev_reg <= 1'b0;
        end else begin
            pin_prev_reg <= pin_level;
        end
    end

    // ****************************************************
    // software registers
    // ****************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            irq_en_reg <= IRQ_EN_RESET;
            prev_source_reg <= SRC_PIN;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= ctrl_next;
            end
            if (wr_irq_en) begin
                irq_en_reg <= reg_wdata & IRQ_EN_WMASK & irq_en_mask;
            end
            prev_source_reg <= src_next;
        end
    end

    // ****************************************************
    // value, capture and compare buffer
    // ****************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            value_reg <= COUNT_ZERO;
            value_written_reg <= 1'b0;
            compare_buffer <= COUNT_ZERO;
            capture_event <= 1'b0;
        end else begin
            capture_event <= 1'b0;
            if (is_capture && ctrl_reg.capture_edge != EDGE_NONE
                && trig_hit) begin
                value_reg <= counter_in.count;
                capture_event <= 1'b1;
            end else if (wr_value) begin
                value_reg <= reg_wdata;
            end
            if (wr_value) begin
                value_written_reg <= 1'b1;
            end else if (load_now) begin
                value_written_reg <= 1'b0;
            end
            if (load_now) begin
                compare_buffer <= value_reg;
            end
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            irq_requests <= 14'h0000;
            counter_reset <= 1'b0;
            reset_value <= COUNT_ZERO;
            timer_output <= 1'b0;
            use_paired_match <= 1'b0;
            match_for_wave <= 1'b0;
            max_for_wave <= 1'b0;
            zero_for_wave <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rdata_next : 16'h0000;
            irq_requests <= irq_sources & irq_en_reg[13:0];
            counter_reset <= !is_capture && prev_match
                && ctrl_reg.buffer_load_mode == LOAD_MATCH_RESET;
            reset_value <= (counter_in.dir == DIR_DOWN)
                ? 16'hFFFF : COUNT_ZERO;
            use_paired_match <= !is_capture
                && ctrl_reg.paired_match_select;
            match_for_wave <= !is_capture && (ctrl_reg.paired_match_select
                ? (own_match | partner_match) : own_match);
            max_for_wave <= !is_capture && !ctrl_reg.paired_match_select
                && counter_in.at_max;
            zero_for_wave <= !is_capture && !ctrl_reg.paired_match_select
                && counter_in.at_zero;
            if (!is_capture
                && ctrl_reg.output_waveform_mode == WAVE_SOFTWARE) begin
                timer_output <= ctrl_reg.software_output_level
                    ^ ctrl_reg.output_invert;
            end
        end
    end

endmodule : timer_compare_capture_control

// file: dv/timer_ccc_assertions.sv
module timer_ccc_assertions
    import ccc_pkg::*;
#(
    parameter logic [5:0] CIRCUIT_PRESENT = 6'h3F
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire counter_view_t counter_in,
    input wire logic capture_input_pin,
    input wire logic own_match,
    input wire logic partner_match,
    input wire logic [13:0] irq_sources,
    input wire logic [13:0] irq_requests,
    input wire logic [15:0] compare_buffer,
    input wire logic counter_reset,
    input wire logic [15:0] reset_value,
    input wire logic capture_event,
    input wire logic timer_output,
    input wire logic use_paired_match,
    input wire logic match_for_wave,
    input wire logic max_for_wave
);
    timeunit 1ns;
    timeprecision 100ps;
    // **********
    // helpers
    // **********
    logic [13:0] keep;
    logic sw_wr;
    always_comb begin
        keep = 14'h0003;
        for (int m = 0; m < 6; m++) begin
            keep[2*m+2 +: 2] = {2{CIRCUIT_PRESENT[m]}};
        end
    end
    assign sw_wr = reg_wr && reg_addr == ADDR_CTRL && !reg_wdata[0]
        && reg_wdata[4:2] == WAVE_SOFTWARE;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_irq_gate;
        (irq_requests & ~$past(irq_sources)) == 14'h0000;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request without source");
    property p_irq_absent;
        (irq_requests & ~keep) == 14'h0000;
    endproperty
    a_irq_absent: assert property (p_irq_absent)
        else $error("request from absent circuit");
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_buf_cause;
        $changed(compare_buffer) |-> $past(reg_wr) || $past(reg_wr, 2)
            || $past(own_match) || $past(counter_in.count == compare_buffer)
            || $past(counter_in.at_max | counter_in.at_zero | counter_in.wrap);
    endproperty
    a_buf_cause: assert property (p_buf_cause)
        else $error("buffer loaded without cause");
    property p_rst_val;
        counter_reset |-> reset_value == ($past(counter_in.dir) == DIR_DOWN
            ? 16'hFFFF : COUNT_ZERO);
    endproperty
    a_rst_val: assert property (p_rst_val)
        else $error("wrong counter reset value");
    property p_rst_cause;
        counter_reset |-> $past(own_match)
            || $past(counter_in.count == compare_buffer);
    endproperty
    a_rst_cause: assert property (p_rst_cause)
        else $error("counter reset without match");
    property p_paired;
        match_for_wave |-> $past(own_match || partner_match);
    endproperty
    a_paired: assert property (p_paired)
        else $error("match without source");
    property p_max;
        max_for_wave |-> !use_paired_match && $past(counter_in.at_max);
    endproperty
    a_max: assert property (p_max)
        else $error("max used wrongly");
    property p_tout;
        $changed(timer_output) |-> $past(sw_wr) || $past(sw_wr, 2);
    endproperty
    a_tout: assert property (p_tout)
        else $error("output moved without software write");
    property p_cap;
        capture_event |-> $past(reg_wr) || $past(reg_wr, 2)
            || $past(capture_input_pin, 2) != $past(capture_input_pin, 7);
    endproperty
    a_cap: assert property (p_cap)
        else $error("capture without trigger");
endmodule : timer_ccc_assertions

bind timer_compare_capture_control timer_ccc_assertions
    #(.CIRCUIT_PRESENT(CIRCUIT_PRESENT)) u_chk (.*);

// file: dv/cap_pin_source.sv
module cap_pin_source (
    input wire logic clk_sys,
    output logic capture_input_pin
);
    timeunit 1ns;
    timeprecision 100ps;
    initial capture_input_pin = 1'b0;
    task automatic drive(input logic lvl);
        @(posedge clk_sys);
        capture_input_pin <= lvl;
    endtask : drive
endmodule : cap_pin_source

// file: dv/timer_compare_capture_control_tb_top.sv
module timer_compare_capture_control_tb_top
    import ccc_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic own_match = 1'b0;
    logic partner_match = 1'b0;
    logic counter_reset, use_paired_match, match_for_wave;
    logic max_for_wave, zero_for_wave;
    logic [15:0] reset_value;
    logic [13:0] irq_sources = 14'h0000;
    counter_view_t counter_in = '{16'hFFF0, 1'b0, 1'b0, 1'b0, DIR_UP};
    logic [15:0] reg_rdata, compare_buffer, cur, nxt, cap;
    logic [13:0] irq_requests;
    logic capture_input_pin, capture_event, timer_output, cap_seen;
    int error_cnt = 0;
    int num_checks = 0;

    always #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (capture_event === 1'b1) cap_seen <= 1'b1;

    cap_pin_source pin (.clk_sys, .capture_input_pin);
    timer_compare_capture_control #(.CIRCUIT_PRESENT(6'h1F)) dut (
        .clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .counter_in, .capture_input_pin, .own_match, .partner_match,
        .irq_sources, .irq_requests, .compare_buffer, .counter_reset,
        .reset_value, .capture_event, .timer_output, .use_paired_match,
        .match_for_wave, .max_for_wave, .zero_for_wave);

    // **********
    // tasks
    // **********
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd
    task automatic trial(input logic [2:0] md, input count_dir_t d,
                         input logic [2:0] f, input logic hp, input logic ld);
        wr(ADDR_CTRL, {1'b0, md, 12'h000});
        nxt = cur + 16'h1111;
        wr(ADDR_VALUE, nxt);
        repeat (3) @(posedge clk_sys);
        #1 chk(compare_buffer, cur);
        @(posedge clk_sys);
        counter_in <= '{hp ? cur : 16'hFFF0, f[2], f[1], f[0], d};
        own_match <= hp;
        @(posedge clk_sys);
        counter_in <= '{16'hFFF0, 1'b0, 1'b0, 1'b0, d};
        own_match <= 1'b0;
        #1 chk({15'h0, counter_reset}, {15'h0, hp && md == 3'h4});
        chk(reset_value, d == DIR_DOWN ? 16'hFFFF : COUNT_ZERO);
        repeat (2) @(posedge clk_sys);
        #1 chk(compare_buffer, ld ? nxt : cur);
        if (ld) cur = nxt;
    endtask : trial
    task automatic cap_try(input logic [15:0] c1, input logic [15:0] c2,
                           input logic lvl, input logic [15:0] cnt,
                           input logic hit);
        @(posedge clk_sys);
        counter_in.count <= cnt;
        #1 cap_seen = 1'b0;
        wr(ADDR_CTRL, c1);
        wr(ADDR_CTRL, c2);
        pin.drive(lvl);
        repeat (8) @(posedge clk_sys);
        #1 chk({15'h0, cap_seen}, {15'h0, hit});
        if (hit) cap = cnt;
        rd(ADDR_VALUE, cap);
    endtask : cap_try
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #20us;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        rd(ADDR_CTRL, CTRL_RESET);
        rd(ADDR_IRQ_EN, IRQ_EN_RESET);
        rd(4'hF, 16'h0000);
        wr(ADDR_IRQ_EN, 16'hFFFF);
        rd(ADDR_IRQ_EN, 16'h0FFF);
        @(posedge clk_sys);
        irq_sources <= 14'h3FFF;
        repeat (2) @(posedge clk_sys);
        #1 chk({2'b00, irq_requests}, 16'h0FFF);
        wr(ADDR_IRQ_EN, 16'h0005);
        repeat (2) @(posedge clk_sys);
        #1 chk({2'b00, irq_requests}, 16'h0005);
        wr(ADDR_CTRL, 16'h00A0);
        rd(ADDR_CTRL, 16'h0020);
        chk({15'h0, timer_output}, 16'h0001);
        wr(ADDR_CTRL, 16'h0000);
        rd(ADDR_CTRL, 16'h0000);
        chk({15'h0, timer_output}, 16'h0000);
        wr(ADDR_CTRL, 16'h0021);
        rd(ADDR_CTRL, 16'h0021);
        chk({15'h0, timer_output}, 16'h0000);
        wr(ADDR_CTRL, 16'h0000);
        wr(ADDR_VALUE, 16'h1234);
        @(posedge clk_sys);
        #1 chk(compare_buffer, 16'h1234);
        cur = 16'h1234;
        trial(3'h1, DIR_UP, 3'b100, 1'b0, 1'b1);
        trial(3'h1, DIR_DOWN, 3'b100, 1'b0, 1'b0);
        trial(3'h1, DIR_DOWN, 3'b010, 1'b0, 1'b1);
        trial(3'h1, DIR_UPDOWN, 3'b100, 1'b0, 1'b1);
        trial(3'h2, DIR_DOWN, 3'b000, 1'b1, 1'b1);
        trial(3'h3, DIR_UP, 3'b100, 1'b0, 1'b0);
        trial(3'h3, DIR_UP, 3'b001, 1'b0, 1'b1);
        trial(3'h3, DIR_DOWN, 3'b001, 1'b0, 1'b1);
        trial(3'h3, DIR_UPDOWN, 3'b000, 1'b1, 1'b1);
        trial(3'h4, DIR_DOWN, 3'b000, 1'b1, 1'b1);
        trial(3'h4, DIR_UP, 3'b000, 1'b1, 1'b1);
        wr(ADDR_CTRL, 16'h0040);
        @(posedge clk_sys);
        partner_match <= 1'b1;
        counter_in.at_max <= 1'b1;
        counter_in.at_zero <= 1'b1;
        @(posedge clk_sys);
        #1 chk({12'h0, use_paired_match, match_for_wave, max_for_wave,
            zero_for_wave}, 16'h000C);
        wr(ADDR_CTRL, 16'h0000);
        @(posedge clk_sys);
        #1 chk({12'h0, use_paired_match, match_for_wave, max_for_wave,
            zero_for_wave}, 16'h0003);
        partner_match <= 1'b0;
        counter_in.at_max <= 1'b0;
        counter_in.at_zero <= 1'b0;
        cap = cur;
        cap_try(16'h8101, 16'h8101, 1'b1, 16'h4321, 1'b1);
        cap_try(16'h8101, 16'h8101, 1'b0, 16'h0777, 1'b0);
        cap_try(16'h0301, 16'h0301, 1'b1, 16'h0ABC, 1'b1);
        cap_try(16'h0201, 16'h0201, 1'b0, 16'h0DEF, 1'b1);
        cap_try(16'h0001, 16'h0001, 1'b1, 16'h0246, 1'b0);
        cap_try(16'h0901, 16'h0D01, 1'b1, 16'h1357, 1'b1);
        cap_try(16'h0E01, 16'h0A01, 1'b1, 16'h2468, 1'b1);
        cap_try(16'h0C01, 16'h0801, 1'b1, 16'h3579, 1'b0);
        tally_and_finish();
    end
endmodule : timer_compare_capture_control_tb_top
